// ---- verilog/fst_top.sv ----
// FIFO error / last byte status and transmit byte count registers
`timescale 1ns/100ps
`include "fst_map.svh"
module fst_top (
    input wire logic mclk,
    input wire logic rst,
    input wire fst_pkg::fst_byte_t reg_addr,
    input wire fst_pkg::fst_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic fifo_rd,
    input wire logic fifo_wr,
    input wire fst_pkg::fst_level_t fifo_level,
    input wire logic rx_end,
    input wire fst_pkg::fst_bits_t rx_last_bits,
    input wire logic rx_parity_missing,
    input wire logic cmd_set_default,
    input wire logic cmd_clear,
    output fst_pkg::fst_byte_t reg_rdata,
    output logic queue_error_irq,
    output fst_pkg::fst_count_t tx_full_count,
    output fst_pkg::fst_bits_t split_byte_bits
);
    logic fifo_unf;
    logic fifo_ovr;
    logic last_incomplete;
    fst_pkg::fst_bits_t last_byte_bitcount;
    logic missing_parity_flag;
    logic next_fifo_unf;
    logic next_fifo_ovr;
    logic next_last_incomplete;
    fst_pkg::fst_bits_t next_last_byte_bitcount;
    logic next_missing_parity_flag;
    logic next_queue_error_irq;
    fst_pkg::fst_count_t next_tx_full_count;
    fst_pkg::fst_bits_t next_split_byte_bits;
    fst_pkg::fst_byte_t next_reg_rdata;
    fst_pkg::fst_byte_t status_byte;
    logic unf_event;
    logic ovr_event;
    logic status_clr;

    assign unf_event = fifo_rd && (fifo_level == `FST_FIFO_EMPTY);
    assign ovr_event = fifo_wr && (fifo_level == `FST_FIFO_FULL);
    assign status_clr = cmd_set_default || cmd_clear;

    always_comb begin
        status_byte = `FST_BYTE_ZERO;
        status_byte[`FST_BIT_UNF] = fifo_unf;
        status_byte[`FST_BIT_OVR] = fifo_ovr;
        status_byte[`FST_BIT_NCP] = last_incomplete;
        status_byte[`FST_LB_MSB:`FST_LB_LSB] = last_byte_bitcount;
        status_byte[`FST_BIT_NP] = missing_parity_flag;
    end

    // Status: a new event in the clearing cycle survives the clear
    always_comb begin
        next_fifo_unf = (fifo_unf && !status_clr) || unf_event;
        next_fifo_ovr = (fifo_ovr && !status_clr) || ovr_event;
        next_last_incomplete = last_incomplete && !status_clr;
        next_last_byte_bitcount = status_clr ? `FST_SPLIT_RESET : last_byte_bitcount;
        next_missing_parity_flag = missing_parity_flag && !status_clr;
        if (rx_end) begin
            next_last_incomplete = (rx_last_bits != `FST_BITS_FULL);
            next_last_byte_bitcount = rx_last_bits;
            next_missing_parity_flag = rx_parity_missing;
        end
        next_queue_error_irq = unf_event || ovr_event;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fifo_unf <= 1'b0;
            fifo_ovr <= 1'b0;
            last_incomplete <= 1'b0;
            last_byte_bitcount <= `FST_SPLIT_RESET;
            missing_parity_flag <= 1'b0;
            queue_error_irq <= 1'b0;
        end else begin
            fifo_unf <= next_fifo_unf;
            fifo_ovr <= next_fifo_ovr;
            last_incomplete <= next_last_incomplete;
            last_byte_bitcount <= next_last_byte_bitcount;
            missing_parity_flag <= next_missing_parity_flag;
            queue_error_irq <= next_queue_error_irq;
        end
    end

    // Count registers; restore-defaults wins over a write in the same cycle
    always_comb begin
        next_tx_full_count = tx_full_count;
        next_split_byte_bits = split_byte_bits;
        if (reg_wr && reg_addr == `FST_ADDR_TXCNT_HI) begin
            next_tx_full_count[`FST_CNT_MSB:`FST_CNT_SPLIT] =
                reg_wdata[`FST_HI_CNT_MSB:0];
        end
        if (reg_wr && reg_addr == `FST_ADDR_TXCNT_LO) begin
            next_tx_full_count[`FST_CNT_SPLIT-1:0] =
                reg_wdata[`FST_LO_CNT_MSB:`FST_LO_CNT_LSB];
            next_split_byte_bits = reg_wdata[`FST_LO_SPLIT_MSB:0];
        end
        if (cmd_set_default) begin
            next_tx_full_count = `FST_TXCNT_RESET;
            next_split_byte_bits = `FST_SPLIT_RESET;
        end
    end

    // Read data is a flop so the SPI side sees a stable byte one cycle later
    always_comb begin
        next_reg_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `FST_ADDR_STATUS2: next_reg_rdata = status_byte;
                `FST_ADDR_TXCNT_HI: begin
                    next_reg_rdata = `FST_BYTE_ZERO;
                    next_reg_rdata[`FST_HI_CNT_MSB:0] =
                        tx_full_count[`FST_CNT_MSB:`FST_CNT_SPLIT];
                end
                `FST_ADDR_TXCNT_LO: next_reg_rdata = {tx_full_count[`FST_CNT_SPLIT-1:0],
                    split_byte_bits};
                default: next_reg_rdata = `FST_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_full_count <= `FST_TXCNT_RESET;
            split_byte_bits <= `FST_SPLIT_RESET;
        end else begin
            tx_full_count <= next_tx_full_count;
            split_byte_bits <= next_split_byte_bits;
        end
    end

    // Read data register kept apart from the counts
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= `FST_BYTE_ZERO;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    sequence s_underflow;
        fifo_rd && fifo_level == `FST_FIFO_EMPTY;
    endsequence
    sequence s_overflow;
        fifo_wr && fifo_level == `FST_FIFO_FULL;
    endsequence

    property p_unf;
        @(posedge mclk) disable iff (rst)
            s_underflow |=> fifo_unf && status_byte[`FST_BIT_UNF];
    endproperty
    a_unf: assert property (p_unf) else $error("underflow flag not set");

    // Clear in the same cycle must not swallow a new underflow
    property p_unf_wins;
        @(posedge mclk) disable iff (rst)
            fifo_rd && fifo_level == `FST_FIFO_EMPTY && (cmd_clear || cmd_set_default)
            |=> fifo_unf;
    endproperty
    a_unf_wins: assert property (p_unf_wins) else $error("underflow lost to clear");

    property p_ovr;
        @(posedge mclk) disable iff (rst)
            s_overflow |=> fifo_ovr && status_byte[`FST_BIT_OVR];
    endproperty
    a_ovr: assert property (p_ovr) else $error("overflow flag not set");

    property p_ncp;
        @(posedge mclk) disable iff (rst)
            rx_end |=> status_byte[`FST_BIT_NCP] == ($past(rx_last_bits) != `FST_BITS_FULL);
    endproperty
    a_ncp: assert property (p_ncp) else $error("incomplete flag wrong");

    property p_lb;
        @(posedge mclk) disable iff (rst)
            rx_end |=> status_byte[`FST_LB_MSB:`FST_LB_LSB] == $past(rx_last_bits);
    endproperty
    a_lb: assert property (p_lb) else $error("last byte bit count wrong");

    property p_np;
        @(posedge mclk) disable iff (rst)
            rx_end |=> status_byte[`FST_BIT_NP] == $past(rx_parity_missing);
    endproperty
    a_np: assert property (p_np) else $error("missing parity flag wrong");

    property p_clear;
        @(posedge mclk) disable iff (rst)
            (cmd_clear || cmd_set_default) && !fifo_rd && !fifo_wr && !rx_end
            |=> status_byte == `FST_BYTE_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");

    property p_hi_wr;
        @(posedge mclk) disable iff (rst)
            reg_wr && reg_addr == `FST_ADDR_TXCNT_HI && !cmd_set_default
            |=> tx_full_count[`FST_CNT_MSB:`FST_CNT_SPLIT] == $past(reg_wdata[`FST_HI_CNT_MSB:0]);
    endproperty
    a_hi_wr: assert property (p_hi_wr) else $error("high count not written");

    property p_lo_wr;
        @(posedge mclk) disable iff (rst)
            reg_wr && reg_addr == `FST_ADDR_TXCNT_LO && !cmd_set_default
            |=> tx_full_count[`FST_CNT_SPLIT-1:0] ==
                $past(reg_wdata[`FST_LO_CNT_MSB:`FST_LO_CNT_LSB])
            && split_byte_bits == $past(reg_wdata[`FST_LO_SPLIT_MSB:0]);
    endproperty
    a_lo_wr: assert property (p_lo_wr) else $error("low count not written");

    property p_default;
        @(posedge mclk) disable iff (rst)
            cmd_set_default
            |=> tx_full_count == `FST_TXCNT_RESET && split_byte_bits == `FST_SPLIT_RESET;
    endproperty
    a_default: assert property (p_default) else $error("count not defaulted");

    property p_irq;
        @(posedge mclk) disable iff (rst)
            (s_underflow or s_overflow) |=> queue_error_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("fifo error irq missing");

    property p_irq_cause;
        @(posedge mclk) disable iff (rst)
            queue_error_irq
            |-> $past(fifo_rd && fifo_level == `FST_FIFO_EMPTY)
            || $past(fifo_wr && fifo_level == `FST_FIFO_FULL);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("spurious fifo error irq");

    // Pulse, not a level: a single event gives a single cycle
    property p_irq_pulse;
        @(posedge mclk) disable iff (rst)
            queue_error_irq && !(fifo_rd && fifo_level == `FST_FIFO_EMPTY)
            && !(fifo_wr && fifo_level == `FST_FIFO_FULL)
            |=> !queue_error_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("fifo error irq too long");

    property p_lo_rd;
        @(posedge mclk) disable iff (rst)
            reg_rd && reg_addr == `FST_ADDR_TXCNT_LO
            |=> reg_rdata == {$past(tx_full_count[`FST_CNT_SPLIT-1:0]), $past(split_byte_bits)};
    endproperty
    a_lo_rd: assert property (p_lo_rd) else $error("low count readback wrong");
endmodule

// ---- verilog/fst_map.svh ----
// Register map, field positions and reset values of the FIFO status / tx count block
`ifndef FST_MAP_SVH
`define FST_MAP_SVH
`define FST_ADDR_STATUS2 8'h0d
`define FST_ADDR_TXCNT_HI 8'h10
`define FST_ADDR_TXCNT_LO 8'h11
`define FST_BIT_UNF 6
`define FST_BIT_OVR 5
`define FST_BIT_NCP 4
`define FST_LB_MSB 3
`define FST_LB_LSB 1
`define FST_BIT_NP 0
`define FST_HI_CNT_MSB 4
`define FST_LO_CNT_MSB 7
`define FST_LO_CNT_LSB 3
`define FST_LO_SPLIT_MSB 2
`define FST_CNT_SPLIT 5
`define FST_CNT_MSB 9
`define FST_FIFO_FULL 6'h20
`define FST_FIFO_EMPTY 6'h00
`define FST_BITS_FULL 3'h0
`define FST_BYTE_ZERO 8'h00
`define FST_TXCNT_RESET 10'h000
`define FST_SPLIT_RESET 3'h0
`endif

// ---- verilog/fst_pkg.sv ----
// Types shared by the FIFO status / tx count block
package fst_pkg;
    typedef logic [7:0] fst_byte_t;
    typedef logic [9:0] fst_count_t;
    typedef logic [2:0] fst_bits_t;
    typedef logic [5:0] fst_level_t;
endpackage

// ---- bench/fst_mcu_model.sv ----
// Controller model driving the register port of the status block
`timescale 1ns/100ps
module fst_mcu_model (
    input wire logic mclk,
    output fst_pkg::fst_byte_t reg_addr,
    output fst_pkg::fst_byte_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Count fields hold ten bits, so at most 1023 is ever written
    // Address and data inverted after use so stale values never look valid
    task automatic wr(input fst_pkg::fst_byte_t a, input fst_pkg::fst_byte_t d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input fst_pkg::fst_byte_t a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the FIFO status and tx count block
`timescale 1ns/100ps
`include "fst_map.svh"
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic fifo_rd = 1'b0, fifo_wr = 1'b0, rx_end = 1'b0, rx_parity_missing = 1'b0;
    logic cmd_set_default = 1'b0, cmd_clear = 1'b0, pend = 1'b0;
    logic reg_wr, reg_rd, queue_error_irq;
    fst_pkg::fst_level_t fifo_level = 6'h00;
    fst_pkg::fst_bits_t rx_last_bits = 3'h0;
    fst_pkg::fst_byte_t reg_addr, reg_wdata, reg_rdata;
    fst_pkg::fst_count_t tx_full_count, cnt;
    fst_pkg::fst_bits_t split_byte_bits, sb;
    fst_pkg::fst_byte_t exp_q[$];
    int errors = 0, comparisons = 0, cyc = 0;
    initial forever #25 mclk = ~mclk;
    fst_mcu_model i_mcu (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    fst_top i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .fifo_rd(fifo_rd), .fifo_wr(fifo_wr),
        .fifo_level(fifo_level), .rx_end(rx_end), .rx_last_bits(rx_last_bits),
        .rx_parity_missing(rx_parity_missing), .cmd_set_default(cmd_set_default),
        .cmd_clear(cmd_clear), .reg_rdata(reg_rdata), .queue_error_irq(queue_error_irq),
        .tx_full_count(tx_full_count), .split_byte_bits(split_byte_bits));
    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic rd(input fst_pkg::fst_byte_t a, input fst_pkg::fst_byte_t e);
        exp_q.push_back(e);
        i_mcu.rd(a);
    endtask
    // One-cycle event: k = {fifo_rd, fifo_wr, rx_end, cmd_clear, cmd_set_default}
    task automatic ev(input logic [4:0] k, input fst_pkg::fst_level_t lv,
        input fst_pkg::fst_bits_t b, input logic irq);
        @(posedge mclk);
        {fifo_rd, fifo_wr, rx_end, cmd_clear, cmd_set_default} <= k;
        fifo_level <= lv;
        rx_last_bits <= b;
        rx_parity_missing <= b[0];
        @(posedge mclk);
        {fifo_rd, fifo_wr, rx_end, cmd_clear, cmd_set_default} <= 5'h00;
        @(negedge mclk);
        chk("queue_error_irq", {9'h000, queue_error_irq}, {9'h000, irq});
    endtask
    // Read data settles one cycle after the sampled request
    always @(posedge mclk) begin
        pend <= reg_rd;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            tally_and_finish;
        end
    end
    always @(negedge mclk) begin
        if (pend) begin
            chk("reg_rdata", {2'b00, reg_rdata}, {2'b00, exp_q.pop_front()});
        end
    end
    initial begin
        void'($urandom(32'h4f2d));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd(`FST_ADDR_STATUS2, 8'h00);
        rd(`FST_ADDR_TXCNT_HI, 8'h00);
        rd(`FST_ADDR_TXCNT_LO, 8'h00);
        cnt = 10'($urandom);
        sb = 3'($urandom);
        i_mcu.wr(`FST_ADDR_TXCNT_HI, {3'b111, cnt[9:5]});
        i_mcu.wr(`FST_ADDR_TXCNT_LO, {cnt[4:0], sb});
        i_mcu.wr(`FST_ADDR_STATUS2, 8'hff);
        rd(8'h3e, 8'h00);
        rd(`FST_ADDR_TXCNT_HI, {3'b000, cnt[9:5]});
        rd(`FST_ADDR_TXCNT_LO, {cnt[4:0], sb});
        @(negedge mclk);
        chk("tx_full_count", tx_full_count, cnt);
        chk("split_byte_bits", {7'h00, split_byte_bits}, {7'h00, sb});
        ev(5'b10000, 6'h01, 3'h0, 1'b0);
        rd(`FST_ADDR_STATUS2, 8'h00);
        ev(5'b10000, 6'h00, 3'h0, 1'b1);
        rd(`FST_ADDR_STATUS2, 8'h40);
        ev(5'b01000, 6'h20, 3'h0, 1'b1);
        rd(`FST_ADDR_STATUS2, 8'h60);
        for (int b = 0; b < 8; b++) begin
            ev(5'b00100, 6'h05, 3'(b), 1'b0);
            rd(`FST_ADDR_STATUS2, {3'b011, b != 0, 3'(b), b[0]});
        end
        ev(5'b00010, 6'h05, 3'h0, 1'b0);
        rd(`FST_ADDR_STATUS2, 8'h00);
        rd(`FST_ADDR_TXCNT_HI, {3'b000, cnt[9:5]});
        ev(5'b10010, 6'h00, 3'h0, 1'b1);
        rd(`FST_ADDR_STATUS2, 8'h40);
        ev(5'b10000, 6'h00, 3'h0, 1'b1);
        ev(5'b00001, 6'h05, 3'h0, 1'b0);
        rd(`FST_ADDR_STATUS2, 8'h00);
        rd(`FST_ADDR_TXCNT_HI, 8'h00);
        rd(`FST_ADDR_TXCNT_LO, 8'h00);
        repeat (3) @(posedge mclk);
        tally_and_finish;
    end
endmodule
